// >>> common/smv_pkg.sv
/*
 * smv_pkg: shared constants for the servo mode and velocity parameter block.
 * Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
 */
package smv_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [5:0] OFF_PRIMARY_MODE = 6'h00;
	localparam logic [5:0] OFF_SEC_MODE_ONE = 6'h04;
	localparam logic [5:0] OFF_SEC_MODE_TWO = 6'h08;
	localparam logic [5:0] OFF_SEC_MODE_THREE = 6'h0C;
	localparam logic [5:0] OFF_VEL_COMMAND = 6'h10;
	localparam logic [5:0] OFF_VEL_FEEDBACK = 6'h14;
	localparam logic [5:0] OFF_HOMING_VEL = 6'h18;
	localparam logic [5:0] OFF_HOMING_ACCEL = 6'h1C;
	localparam logic [5:0] OFF_VEL_POLARITY = 6'h20;
	localparam logic [5:0] OFF_PHASE = 6'h24;
	localparam logic [5:0] OFF_STATUS = 6'h28;
	localparam logic [5:0] OFF_REJECT = 6'h2C;

	// ---------------------------------------------------------------
	// field positions and widths
	// ---------------------------------------------------------------
	localparam int POL_CMD_BIT = 0;
	localparam int POL_FB_BIT = 2;
	localparam logic [15:0] POL_WRITE_MASK = 16'h0005;
	localparam int PHASE_W = 3;
	localparam int MODE_SEL_W = 2;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [15:0] POL_RESET = 16'h0000;

	// ---------------------------------------------------------------
	// mode codes, communication phases, limits
	// ---------------------------------------------------------------
	localparam logic [15:0] MODE_NONE = 16'h0000;
	localparam logic [15:0] MODE_TORQUE_CYC = 16'h0001;
	localparam logic [15:0] MODE_VEL_CYC = 16'h0002;
	localparam logic [15:0] MODE_POS_CYC = 16'h0003;
	localparam logic [15:0] MODE_TORQUE_NOCYC = 16'h4001;
	localparam logic [15:0] MODE_VEL_NOCYC = 16'h4002;
	localparam logic [2:0] PHASE_TWO = 3'h2;
	localparam logic [2:0] PHASE_FOUR = 3'h4;
	localparam logic [31:0] VEL_MAX = 32'h0000_8000;
	localparam logic [31:0] VEL_MIN = 32'hFFFF_8000;
	localparam logic [31:0] ACCEL_MAX = 32'h017D_7840;

	// decoded operating mode
	typedef enum logic [2:0] {
		SMV_OP_NONE,
		SMV_OP_TORQUE,
		SMV_OP_VELOCITY,
		SMV_OP_POSITION,
		SMV_OP_TORQUE_FREE,
		SMV_OP_VELOCITY_FREE,
		SMV_OP_INVALID
	} smv_op_e;
endpackage : smv_pkg

// >>> logic/smv_mode_decode.sv
/*
 * smv_mode_decode: turns a 16-bit mode parameter into an operating mode.
 * Assumes the caller registers the result.
 */
`timescale 1ns/10ps
module smv_mode_decode (
	// parameter value
	input wire logic [15:0] code_in,
	// decoded mode
	output smv_pkg::smv_op_e op_out
);
	// ---------------------------------------------------------------
	// decode table
	// ---------------------------------------------------------------
	always_comb begin
		case (code_in)
			smv_pkg::MODE_NONE: op_out = smv_pkg::SMV_OP_NONE;
			smv_pkg::MODE_TORQUE_CYC: op_out = smv_pkg::SMV_OP_TORQUE;
			smv_pkg::MODE_VEL_CYC: op_out = smv_pkg::SMV_OP_VELOCITY;
			smv_pkg::MODE_POS_CYC: op_out = smv_pkg::SMV_OP_POSITION;
			smv_pkg::MODE_TORQUE_NOCYC: op_out = smv_pkg::SMV_OP_TORQUE_FREE;
			smv_pkg::MODE_VEL_NOCYC: op_out = smv_pkg::SMV_OP_VELOCITY_FREE;
			default: op_out = smv_pkg::SMV_OP_INVALID;
		endcase
	end
endmodule : smv_mode_decode

// >>> logic/smv_params.sv
/*
 * smv_params: operation-mode and velocity parameters of a servo drive,
 * reached over AXI4-Lite, with phase-gated writes and polarity inversion.
 * Assumes phase, control word and feedback come from logic on clk_in.
 */
`timescale 1ns/10ps
// Behaviour
// - primary select adopts primary mode parameter
// - mode codes decode to six operating modes
// - secondary one select adopts its parameter
// - secondary two select adopts its parameter
// - secondary three select adopts its parameter
// - drive reports signed read-only velocity feedback
// - homing velocity held, written in phase four
// - homing acceleration held, written in phase four
// - polarity bits invert command and feedback
// - inversion only at loop input and output
// - positive command with no inversion is clockwise
module smv_params (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [5:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [5:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// ring state from the telegram logic
	input wire logic [2:0] comm_phase_in,
	input wire logic [1:0] mode_select_in,
	// raw velocity feedback from the loop
	input wire logic [31:0] loop_vel_fb_in,
	// loop-facing outputs
	output smv_pkg::smv_op_e active_mode_out,
	output logic [31:0] loop_vel_cmd_out,
	output logic [31:0] homing_vel_out,
	output logic [31:0] homing_accel_out
);
	// ---------------------------------------------------------------
	// parameter storage
	// ---------------------------------------------------------------
	logic [15:0] mode_q [4]; // primary, secondary one to three
	logic [31:0] vel_cmd_q; // command as written by the master
	logic [31:0] vel_fb_q; // feedback after polarity
	logic [31:0] homing_vel_q;
	logic [31:0] homing_accel_q;
	logic [15:0] polarity_q;
	logic [31:0] reject_cnt_q; // count of refused writes
	smv_pkg::smv_op_e op_dec [4]; // decoded parameters

	// ---------------------------------------------------------------
	// axi write channel state
	// ---------------------------------------------------------------
	logic aw_held_q; // address captured
	logic w_held_q; // data captured
	logic [5:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_go; // both halves present, no response pending
	logic wr_ok; // address mapped, writable, phase allowed
	logic wr_hit_rw; // address names a writable register
	logic [31:0] wr_merged; // old word with strobed bytes replaced
	logic [31:0] wr_old;
	logic ar_go;
	logic [31:0] rd_word;
	logic rd_hit;

	// ---------------------------------------------------------------
	// write address and data capture, either order
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 6'h00;
		end else if (wr_go) begin
			aw_held_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wr_go) begin
			w_held_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	// ready while not holding a half and no response outstanding
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_held_q || (s_axi_awvalid && s_axi_awready)) && !wr_go
				&& !s_axi_bvalid;
			s_axi_wready <= !(w_held_q || (s_axi_wvalid && s_axi_wready)) && !wr_go
				&& !s_axi_bvalid;
		end
	end

	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

	// ---------------------------------------------------------------
	// write decode: phase gate per register
	// ---------------------------------------------------------------
	always_comb begin
		wr_hit_rw = 1'b1;
		wr_ok = 1'b0;
		wr_old = 32'h0000_0000;
		case (aw_addr_q)
			smv_pkg::OFF_PRIMARY_MODE, smv_pkg::OFF_SEC_MODE_ONE,
			smv_pkg::OFF_SEC_MODE_TWO, smv_pkg::OFF_SEC_MODE_THREE: begin
				wr_ok = (comm_phase_in == smv_pkg::PHASE_TWO);
				wr_old = {16'h0000, mode_q[aw_addr_q[3:2]]};
			end
			smv_pkg::OFF_VEL_COMMAND: begin
				wr_ok = (comm_phase_in == smv_pkg::PHASE_FOUR);
				wr_old = vel_cmd_q;
			end
			smv_pkg::OFF_HOMING_VEL: begin
				wr_ok = (comm_phase_in == smv_pkg::PHASE_FOUR);
				wr_old = homing_vel_q;
			end
			smv_pkg::OFF_HOMING_ACCEL: begin
				wr_ok = (comm_phase_in == smv_pkg::PHASE_FOUR);
				wr_old = homing_accel_q;
			end
			smv_pkg::OFF_VEL_POLARITY: begin
				// writable in phases two to four
				wr_ok = (comm_phase_in >= smv_pkg::PHASE_TWO)
					&& (comm_phase_in <= smv_pkg::PHASE_FOUR);
				wr_old = {16'h0000, polarity_q};
			end
			default: begin
				wr_hit_rw = 1'b0;
			end
		endcase
	end

	// byte-lane merge, one lane per strobe bit
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wr_merged[gi*8 +: 8] = w_strb_q[gi] ? w_data_q[gi*8 +: 8] : wr_old[gi*8 +: 8];
		end
	endgenerate

	// ---------------------------------------------------------------
	// parameter registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 4; i++) begin
				mode_q[i] <= smv_pkg::MODE_RESET;
			end
		end else if (wr_go && wr_ok && (aw_addr_q <= smv_pkg::OFF_SEC_MODE_THREE)) begin
			mode_q[aw_addr_q[3:2]] <= wr_merged[15:0];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vel_cmd_q <= smv_pkg::WORD_RESET;
			homing_vel_q <= smv_pkg::WORD_RESET;
			homing_accel_q <= smv_pkg::WORD_RESET;
			polarity_q <= smv_pkg::POL_RESET;
		end else if (wr_go && wr_ok) begin
			case (aw_addr_q)
				smv_pkg::OFF_VEL_COMMAND: vel_cmd_q <= wr_merged;
				smv_pkg::OFF_HOMING_VEL: homing_vel_q <= wr_merged;
				smv_pkg::OFF_HOMING_ACCEL: homing_accel_q <= wr_merged;
				// reserved polarity bits stay zero
				smv_pkg::OFF_VEL_POLARITY: polarity_q <= wr_merged[15:0] & smv_pkg::POL_WRITE_MASK;
				default: begin
				end
			endcase
		end
	end

	// refused writes are counted so software can see them
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reject_cnt_q <= smv_pkg::WORD_RESET;
		end else if (wr_go && wr_hit_rw && !wr_ok) begin
			reject_cnt_q <= reject_cnt_q + 32'h0000_0001;
		end
	end

	// write response: slverr for refused or unmapped
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// mode selection and loop interface
	// ---------------------------------------------------------------
	generate
		for (gi = 0; gi < 4; gi++) begin : g_dec
			smv_mode_decode u_dec (
				.code_in(mode_q[gi]),
				.op_out(op_dec[gi])
			);
		end
	endgenerate

	// control word select 0..3 picks primary, secondary one..three
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			active_mode_out <= smv_pkg::SMV_OP_NONE;
		end else begin
			case (mode_select_in)
				2'h0: active_mode_out <= op_dec[0];
				2'h1: active_mode_out <= op_dec[1];
				2'h2: active_mode_out <= op_dec[2];
				2'h3: active_mode_out <= op_dec[3];
				default: active_mode_out <= smv_pkg::SMV_OP_NONE;
			endcase
		end
	end

	// inversion applied at the loop boundary only, never inside it
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			loop_vel_cmd_out <= smv_pkg::WORD_RESET;
			vel_fb_q <= smv_pkg::WORD_RESET;
		end else begin
			// positive command with bit clear means clockwise
			loop_vel_cmd_out <= polarity_q[smv_pkg::POL_CMD_BIT]
				? (32'h0000_0000 - vel_cmd_q) : vel_cmd_q;
			vel_fb_q <= polarity_q[smv_pkg::POL_FB_BIT]
				? (32'h0000_0000 - loop_vel_fb_in) : loop_vel_fb_in;
		end
	end

	// homing values go to the drive's own homing control
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			homing_vel_out <= smv_pkg::WORD_RESET;
			homing_accel_out <= smv_pkg::WORD_RESET;
		end else begin
			homing_vel_out <= homing_vel_q;
			homing_accel_out <= homing_accel_q;
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			smv_pkg::OFF_PRIMARY_MODE, smv_pkg::OFF_SEC_MODE_ONE,
			smv_pkg::OFF_SEC_MODE_TWO, smv_pkg::OFF_SEC_MODE_THREE:
				rd_word = {16'h0000, mode_q[s_axi_araddr[3:2]]};
			smv_pkg::OFF_VEL_COMMAND: rd_word = vel_cmd_q;
			smv_pkg::OFF_VEL_FEEDBACK: rd_word = vel_fb_q;
			smv_pkg::OFF_HOMING_VEL: rd_word = homing_vel_q;
			smv_pkg::OFF_HOMING_ACCEL: rd_word = homing_accel_q;
			smv_pkg::OFF_VEL_POLARITY: rd_word = {16'h0000, polarity_q};
			smv_pkg::OFF_PHASE: rd_word = {29'h0000_0000, comm_phase_in};
			smv_pkg::OFF_STATUS: rd_word = {27'h000_0000, mode_select_in, active_mode_out};
			smv_pkg::OFF_REJECT: rd_word = reject_cnt_q;
			default: begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign ar_go = s_axi_arvalid && s_axi_arready;

	// one read at a time; arready drops while data is pending
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (ar_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule : smv_params

// >>> verif/smv_params_assertions.sv
/*
 * checker for the servo mode and velocity parameter block, bound to its ports.
 * assumes a single clock domain and a master that offers address and data together.
 */
`timescale 1ns/10ps
module smv_params_chk (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// ring state and loop side
	input wire logic [2:0] comm_phase_in,
	input wire logic [1:0] mode_select_in,
	input smv_pkg::smv_op_e active_mode_out,
	input wire logic [31:0] loop_vel_cmd_out,
	input wire logic [31:0] homing_vel_out,
	input wire logic [31:0] homing_accel_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ---------------------------------------------------------------
	// helper ages since the last write or mode-select change
	// ---------------------------------------------------------------
	logic [2:0] wr_age_q; // cycles since write address taken
	logic [2:0] quiet_q; // cycles with no write and no select change
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) wr_age_q <= 3'h0;
		else if (s_axi_awvalid && s_axi_awready) wr_age_q <= 3'h0;
		else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) quiet_q <= 3'h0;
		else if ((s_axi_awvalid && s_axi_awready) || $changed(mode_select_in)) quiet_q <= 3'h0;
		else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
	end
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_write_resp_time: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after handshake");
	a_write_ready_drop: assert property (
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("write address ready did not drop");
	a_bvalid_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");
	a_read_resp_time: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after address");
	a_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before acceptance");
	a_mode_settles: assert property (
		quiet_q >= 3'h5 |-> $stable(active_mode_out))
		else $error("active mode moved with no cause");
	a_cmd_needs_write: assert property (
		$changed(loop_vel_cmd_out) |-> wr_age_q < 3'h5)
		else $error("velocity command moved without a write");
	// the output follows the commit by one edge, so the commit's phase is two cycles back; this checks the phase one cycle back
	a_homing_vel_phase: assert property (
		$changed(homing_vel_out) |-> $past(comm_phase_in) == smv_pkg::PHASE_FOUR)
		else $error("homing velocity changed outside phase four");
	a_homing_acc_phase: assert property (
		$changed(homing_accel_out) |-> $past(comm_phase_in) == smv_pkg::PHASE_FOUR)
		else $error("homing acceleration changed outside phase four");
endmodule : smv_params_chk

bind smv_params smv_params_chk u_smv_params_chk (.clk_in, .rstn_in, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .comm_phase_in,
	.mode_select_in, .active_mode_out, .loop_vel_cmd_out, .homing_vel_out, .homing_accel_out);

// >>> verif/smv_params_tb.sv
/*
 * self-checking bench for the parameter block, driving its register bus.
 * assumes the ring model supplies phase, select word and feedback.
 */
`timescale 1ns/10ps
module smv_params_tb;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk_in, rstn_in;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, loop_vel_fb_in, loop_vel_cmd_out;
	logic [31:0] homing_vel_out, homing_accel_out, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, mode_select_in, rr;
	logic [2:0] comm_phase_in;
	smv_pkg::smv_op_e active_mode_out;
	int error_cnt = 0;
	int checks_done = 0;
	// mode codes in enum order, last one undefined
	logic [15:0] codes [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h4001, 16'h4002, 16'h1234};
	smv_params u_smv_params (.clk_in, .rstn_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .comm_phase_in, .mode_select_in, .loop_vel_fb_in,
		.active_mode_out, .loop_vel_cmd_out, .homing_vel_out, .homing_accel_out);
	smv_ring_model u_smv_ring_model (.clk_in, .rstn_in, .loop_vel_cmd_in(loop_vel_cmd_out),
		.comm_phase_out(comm_phase_in), .mode_select_out(mode_select_in),
		.loop_vel_fb_out(loop_vel_fb_in));
	// clock at 100 MHz
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one write, response compared with the expected code
	task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		chk("write done", 1, {31'h0, n < 50});
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		repeat (3) @(posedge clk_in);
	endtask : axi_write
	// one read, data and code handed back
	task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk("read done", 1, {31'h0, n < 50});
		repeat (2) @(posedge clk_in);
	endtask : axi_read
	// read and compare one word with an okay code
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		axi_read(a, rd, rr);
		chk("read data", e, rd);
		chk("rresp", 32'h0, {30'h0, rr});
	endtask : rd_chk
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values;
		for (int i = 0; i < 9; i++) rd_chk(6'(4 * i), 32'h0);
	endtask : t_reset_values
	task automatic t_modes;
		u_smv_ring_model.set_state(3'h2, 2'h0);
		for (int i = 0; i < 7; i++) begin
			axi_write(smv_pkg::OFF_PRIMARY_MODE, {16'h0, codes[i]}, 2'h0);
			chk("primary mode", 32'(i), {29'h0, active_mode_out});
		end
		for (int i = 1; i < 4; i++) axi_write(6'(4 * i), {16'h0, codes[i + 2]}, 2'h0);
		for (int i = 1; i < 4; i++) begin
			u_smv_ring_model.set_state(3'h2, 2'(i));
			repeat (3) @(posedge clk_in);
			chk("secondary mode", 32'(i + 2), {29'h0, active_mode_out});
			rd_chk(6'(4 * i), {16'h0, codes[i + 2]});
			// status word: select in bits 4..3, active mode in bits 2..0
			rd_chk(smv_pkg::OFF_STATUS, {27'h0, 2'(i), 3'(i + 2)});
		end
		u_smv_ring_model.set_state(3'h2, 2'h0);
	endtask : t_modes
	task automatic t_refuse;
		u_smv_ring_model.set_state(3'h4, 2'h0);
		axi_write(smv_pkg::OFF_PRIMARY_MODE, 32'h1, 2'h2);
		rd_chk(smv_pkg::OFF_PRIMARY_MODE, 32'h1234);
		chk("mode kept", 32'h6, {29'h0, active_mode_out});
		u_smv_ring_model.set_state(3'h2, 2'h0);
		axi_write(smv_pkg::OFF_VEL_COMMAND, 32'h40, 2'h2);
		rd_chk(smv_pkg::OFF_VEL_COMMAND, 32'h0);
		rd_chk(smv_pkg::OFF_REJECT, 32'h2);
		rd_chk(smv_pkg::OFF_PHASE, 32'h2);
	endtask : t_refuse
	task automatic t_velocity;
		u_smv_ring_model.set_state(3'h4, 2'h0);
		axi_write(smv_pkg::OFF_VEL_COMMAND, 32'h100, 2'h0);
		rd_chk(smv_pkg::OFF_PHASE, 32'h4);
		chk("command out", 32'h100, loop_vel_cmd_out);
		rd_chk(smv_pkg::OFF_VEL_FEEDBACK, 32'h100);
		axi_write(smv_pkg::OFF_VEL_POLARITY, 32'hFFFF, 2'h0);
		rd_chk(smv_pkg::OFF_VEL_POLARITY, 32'h5);
		chk("command inverted", 32'hFFFF_FF00, loop_vel_cmd_out);
		rd_chk(smv_pkg::OFF_VEL_FEEDBACK, 32'h100);
		axi_write(smv_pkg::OFF_VEL_POLARITY, 32'h1, 2'h0);
		rd_chk(smv_pkg::OFF_VEL_FEEDBACK, 32'hFFFF_FF00);
		axi_write(smv_pkg::OFF_VEL_FEEDBACK, 32'h7, 2'h2);
		axi_read(6'h30, rd, rr);
		chk("unmapped rresp", 32'h2, {30'h0, rr});
	endtask : t_velocity
	task automatic t_homing;
		axi_write(smv_pkg::OFF_HOMING_VEL, 32'h8000, 2'h0);
		axi_write(smv_pkg::OFF_HOMING_ACCEL, smv_pkg::ACCEL_MAX, 2'h0);
		chk("homing vel", 32'h8000, homing_vel_out);
		chk("homing accel", smv_pkg::ACCEL_MAX, homing_accel_out);
		u_smv_ring_model.set_state(3'h3, 2'h0);
		axi_write(smv_pkg::OFF_HOMING_VEL, 32'h1, 2'h2);
		chk("homing kept", 32'h8000, homing_vel_out);
		axi_write(smv_pkg::OFF_HOMING_ACCEL, 32'h1, 2'h2);
		chk("accel kept", smv_pkg::ACCEL_MAX, homing_accel_out);
	endtask : t_homing
	// verdict and end of run
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	// watchdog well beyond the expected few hundred cycles
	initial begin
		#200us;
		error_cnt++;
		$display("BAD watchdog expected done seen hang");
		final_report();
	end
	// main sequence
	initial begin
		rstn_in = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 6'h00;
		s_axi_araddr = 6'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		t_reset_values();
		t_modes();
		t_refuse();
		t_velocity();
		t_homing();
		final_report();
	end
endmodule : smv_params_tb

// >>> verif/smv_ring_model.sv
/*
 * ring master model: drives phase and control word, and closes the loop.
 * assumes the same clock as the parameter block.
 */
`timescale 1ns/10ps
module smv_ring_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// command leaving the block
	input wire logic [31:0] loop_vel_cmd_in,
	// ring state and feedback
	output logic [2:0] comm_phase_out,
	output logic [1:0] mode_select_out,
	output logic [31:0] loop_vel_fb_out
);
	// loop stand-in: shaft speed follows the command a cycle later
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) loop_vel_fb_out <= 32'h0000_0000;
		else loop_vel_fb_out <= loop_vel_cmd_in;
	end
	// master moves phase and select word just after an edge
	task automatic set_state(input logic [2:0] p, input logic [1:0] s);
		@(posedge clk_in);
		comm_phase_out <= p;
		mode_select_out <= s;
	endtask : set_state
	// start in phase two with primary selected
	initial begin
		comm_phase_out = 3'h2;
		mode_select_out = 2'h0;
	end
endmodule : smv_ring_model
